// ### reset_boot_consts.vh
`ifndef RESET_BOOT_CONSTS_VH
`define RESET_BOOT_CONSTS_VH

// ----------------------------------------------------------------
// Lock latency
// ----------------------------------------------------------------
`define LOCK_CYCLES 4096
`define LOCK_CNT_W 13

// ----------------------------------------------------------------
// Start-up ratio pin codes and ratios
// ----------------------------------------------------------------
`define RATIO_CODE_6 2'h0
`define RATIO_CODE_32 2'h1
`define RATIO_CODE_16 2'h2
`define RATIO_CODE_RSVD 2'h3
`define RATIO_6 6'h06
`define RATIO_32 6'h20
`define RATIO_16 6'h10
`define RATIO_W 6

// ----------------------------------------------------------------
// Reset vector
// ----------------------------------------------------------------
`define RESET_VECTOR 24'h090000
`define VECTOR_W 24

`endif

// ### sync3.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Three-stage synchroniser; output moves once stages two and three agree
// ----------------------------------------------------------------
module sync3 #(
    parameter RESET_VAL = 1'b0
) (
    input wire ref_clk, // Clock
    input wire rstn, // Asynchronous reset, active low
    input wire din, // Asynchronous input
    output reg dout // Filtered synchronous level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // sync3

// ### reset_boot_sequencing.v
`timescale 1ns/1ps
`include "reset_boot_consts.vh"

module reset_boot_sequencing #(
    parameter LOCK_CYCLES = `LOCK_CYCLES
) (
    input wire ref_clk, // Reference clock, 200 MHz
    input wire rstn, // Reset input, active low
    input wire [1:0] boot_select_pins, // Boot mode select straps
    input wire [1:0] startup_ratio_pins, // Start-up clock ratio straps
    input wire test_rst_n, // Test reset, active low
    input wire scan_shift, // Scan output being shifted
    input wire scan_data, // Scan data from the scan path
    input wire rd_n_core, // Core read strobe
    input wire wr_n_core, // Core write strobe
    input wire ale_core, // Core address-latch strobe
    output reg reset_output_pin_n, // Reset to external devices, low
    output reg core_run, // Core may execute
    output reg [23:0] fetch_addr, // First fetch address
    output reg [1:0] boot_mode, // Captured boot mode
    output reg [5:0] clk_ratio, // Captured core-to-reference ratio
    output reg ratio_reserved, // Ratio pins held reserved code
    output reg test_port_reset, // Test-port machine in reset
    output reg rd_n_out, // Read strobe pin value
    output reg rd_n_oe_n, // Read strobe enable, low drives
    output reg wr_n_out, // Write strobe pin value
    output reg wr_n_oe_n, // Write strobe enable, low drives
    output reg ale_out, // Address-latch pin value
    output reg ale_oe_n, // Address-latch enable, low drives
    output reg tdo_out, // Test data out value
    output reg tdo_oe_n, // Test data out enable, low drives
    output reg in_pins_oe_n, // Input-only pin drivers, high off
    output reg in_pins_pu_en, // Input-only pin pull-ups
    output reg out_pins_oe_n // Output-only pin drivers, low drives
);
    // ------------------------------------------------------------
    // Reset release synchronisation
    // ------------------------------------------------------------
    wire rst_sync;
    wire trst_sync;
    wire [1:0] boot_sync;
    wire [1:0] ratio_sync;
    reg [`LOCK_CNT_W-1:0] lock_cnt;
    reg locked;
    reg straps_taken;
    reg [`RATIO_W-1:0] next_ratio;

    // Constant high input: rises a few edges after release
    sync3 #(.RESET_VAL(1'b0)) u_rst_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(1'b1),
        .dout(rst_sync)
    );

    sync3 #(.RESET_VAL(1'b0)) u_trst_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(test_rst_n),
        .dout(trst_sync)
    );

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------
    // Straps settle at the same edge as the released reset
    sync3 #(.RESET_VAL(1'b0)) u_boot_sync0 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(boot_select_pins[0]),
        .dout(boot_sync[0])
    );

    sync3 #(.RESET_VAL(1'b0)) u_boot_sync1 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(boot_select_pins[1]),
        .dout(boot_sync[1])
    );

    sync3 #(.RESET_VAL(1'b0)) u_ratio_sync0 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(startup_ratio_pins[0]),
        .dout(ratio_sync[0])
    );

    sync3 #(.RESET_VAL(1'b0)) u_ratio_sync1 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(startup_ratio_pins[1]),
        .dout(ratio_sync[1])
    );

    // ------------------------------------------------------------
    // Start-up ratio decode
    // ------------------------------------------------------------
    always @* begin
        case (ratio_sync)
            `RATIO_CODE_6: next_ratio = `RATIO_6;
            `RATIO_CODE_32: next_ratio = `RATIO_32;
            `RATIO_CODE_16: next_ratio = `RATIO_16;
            default: next_ratio = `RATIO_6;
        endcase
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            straps_taken <= 1'b0;
            boot_mode <= 2'h0;
            clk_ratio <= `RATIO_6;
            ratio_reserved <= 1'b0;
        end else if (rst_sync && !straps_taken) begin
            // Filtered straps caught once; later changes are ignored
            straps_taken <= 1'b1;
            boot_mode <= boot_sync;
            clk_ratio <= next_ratio;
            ratio_reserved <= (ratio_sync == `RATIO_CODE_RSVD);
        end
    end

    // ------------------------------------------------------------
    // Lock counter
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lock_cnt <= {`LOCK_CNT_W{1'b0}};
            locked <= 1'b0;
        end else if (rst_sync && !locked) begin
            if (lock_cnt == LOCK_CYCLES - 1) begin
                locked <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Core start and reset output
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_run <= 1'b0;
            fetch_addr <= `RESET_VECTOR;
            reset_output_pin_n <= 1'b0;
        end else begin
            core_run <= locked;
            fetch_addr <= `RESET_VECTOR;
            reset_output_pin_n <= locked;
        end
    end

    // ------------------------------------------------------------
    // Test port reset
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            test_port_reset <= 1'b1;
        end else begin
            test_port_reset <= !trst_sync;
        end
    end

    // ------------------------------------------------------------
    // Bus strobes
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_n_out <= 1'b1;
            rd_n_oe_n <= 1'b1;
            wr_n_out <= 1'b1;
            wr_n_oe_n <= 1'b1;
            ale_out <= 1'b0;
            ale_oe_n <= 1'b1;
        end else begin
            rd_n_out <= rd_n_core;
            rd_n_oe_n <= !rst_sync;
            wr_n_out <= wr_n_core;
            wr_n_oe_n <= !rst_sync;
            ale_out <= ale_core;
            ale_oe_n <= !rst_sync;
        end
    end

    // ------------------------------------------------------------
    // Test data out
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tdo_out <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            tdo_out <= scan_data;
            tdo_oe_n <= !(scan_shift && trst_sync);
        end
    end

    // ------------------------------------------------------------
    // Fixed-direction pins
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            in_pins_oe_n <= 1'b1;
            in_pins_pu_en <= 1'b0;
            out_pins_oe_n <= 1'b0;
        end else begin
            in_pins_oe_n <= 1'b1;
            in_pins_pu_en <= 1'b0;
            out_pins_oe_n <= 1'b0;
        end
    end
endmodule // reset_boot_sequencing

// ### rbs_chk.sv
`timescale 1ns/1ps
module rbs_chk #(
    parameter LOCK_CYCLES = 4096
) (
    input wire ref_clk, // Clock
    input wire rstn, // Reset, active low
    input wire core_run, // Core may execute
    input wire reset_output_pin_n, // Reset out
    input wire [23:0] fetch_addr, // Start address
    input wire [5:0] clk_ratio, // Ratio
    input wire ratio_reserved, // Reserved ratio flag
    input wire rd_n_oe_n, // Read strobe enable
    input wire wr_n_oe_n, // Write strobe enable
    input wire ale_oe_n, // Address-latch enable
    input wire tdo_oe_n, // Test data out enable
    input wire scan_shift, // Scan shifting
    input wire in_pins_oe_n, // Input-only drivers
    input wire in_pins_pu_en, // Input-only pull-ups
    input wire out_pins_oe_n // Output-only drivers
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    int cnt;
    // Cycles since reset release
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
        end else if (cnt < 9999) begin
            cnt <= cnt + 1;
        end
    end
    a_run_out_tie: assert property (core_run == reset_output_pin_n)
        else $error("reset out differs from run");
    a_run_vector: assert property (core_run |-> fetch_addr == 24'h090000)
        else $error("wrong start address");
    a_lock_wait: assert property (core_run |-> cnt >= LOCK_CYCLES)
        else $error("core ran early");
    a_lock_bound: assert property (cnt >= LOCK_CYCLES + 10 |-> core_run)
        else $error("core never ran");
    a_strobe_drive: assert property (cnt >= 8 |->
        !rd_n_oe_n && !wr_n_oe_n && !ale_oe_n)
        else $error("strobe not driven");
    a_tdo_quiet: assert property (!tdo_oe_n |->
        $past(scan_shift) || $past(scan_shift, 2))
        else $error("tdo driven without shift");
    a_fixed_pins: assert property (in_pins_oe_n && !in_pins_pu_en &&
        !out_pins_oe_n)
        else $error("fixed pin enable wrong");
    a_ratio_flag: assert property (ratio_reserved |-> clk_ratio == 6'h06)
        else $error("reserved ratio wrong");
    cover property (core_run);
    cover property (!tdo_oe_n);
    cover property (ratio_reserved && core_run);
endmodule // rbs_chk
bind reset_boot_sequencing rbs_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (
    .ref_clk, .rstn, .core_run, .reset_output_pin_n, .fetch_addr, .clk_ratio,
    .ratio_reserved, .rd_n_oe_n, .wr_n_oe_n, .ale_oe_n, .tdo_oe_n,
    .scan_shift, .in_pins_oe_n, .in_pins_pu_en, .out_pins_oe_n);

// ### board_src.sv
`timescale 1ns/1ps
module board_src (
    input wire ref_clk, // Clock
    output reg rstn = 1'b0, // Board reset, held low at power-up
    output reg [1:0] boot_select_pins = 2'h0, // Boot straps
    output reg [1:0] startup_ratio_pins = 2'h0, // Ratio straps
    output reg test_rst_n = 1'b0, // Emulator test reset
    output reg test_clk = 1'b0 // Test clock held low
);
    task set_trst(input v);
        @(posedge ref_clk);
        test_rst_n <= v;
    endtask
    task power_up(input [1:0] b, input [1:0] r);
        @(posedge ref_clk);
        boot_select_pins <= b;
        startup_ratio_pins <= r;
        @(posedge ref_clk);
        rstn <= 1'b0;
        test_rst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        test_rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        boot_select_pins <= ~b; // Late strap changes must be ignored
        startup_ratio_pins <= ~r;
    endtask
endmodule // board_src

// ### tb_reset_boot_sequencing.sv
`timescale 1ns/1ps
module tb_reset_boot_sequencing;
    reg ref_clk = 1'b0, rd_n_core = 1'b1, wr_n_core = 1'b1, ale_core = 1'b0;
    reg scan_shift = 1'b0, scan_data = 1'b0;
    wire rstn, test_rst_n, reset_output_pin_n, core_run, ratio_reserved;
    wire [1:0] boot_select_pins, startup_ratio_pins, boot_mode;
    wire [5:0] clk_ratio;
    wire [23:0] fetch_addr;
    wire test_port_reset, rd_n_out, rd_n_oe_n, wr_n_out, wr_n_oe_n, ale_out;
    wire ale_oe_n, tdo_out, tdo_oe_n, in_pins_oe_n, in_pins_pu_en;
    wire out_pins_oe_n;
    int num_errors = 0, check_count = 0, cycles = 0, n;
    initial forever #2.5 ref_clk = ~ref_clk;
    board_src board_src_i (.ref_clk, .rstn, .boot_select_pins,
        .startup_ratio_pins, .test_rst_n, .test_clk());
    reset_boot_sequencing #(.LOCK_CYCLES(16)) reset_boot_sequencing_i (
        .ref_clk, .rstn, .boot_select_pins, .startup_ratio_pins, .test_rst_n,
        .scan_shift, .scan_data, .rd_n_core, .wr_n_core, .ale_core,
        .reset_output_pin_n, .core_run, .fetch_addr, .boot_mode, .clk_ratio,
        .ratio_reserved, .test_port_reset, .rd_n_out, .rd_n_oe_n, .wr_n_out,
        .wr_n_oe_n, .ale_out, .ale_oe_n, .tdo_out, .tdo_oe_n, .in_pins_oe_n,
        .in_pins_pu_en, .out_pins_oe_n);
    task check(input string what, input [23:0] exp, input [23:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task conclude;
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task t_boot(input [1:0] r, input [5:0] ratio);
        board_src_i.power_up(2'h2 ^ r, r);
        #1;
        check("reset out early", 0, reset_output_pin_n);
        for (n = 3; core_run !== 1'b1 && n < 60; n++) @(posedge ref_clk) #1;
        check("lock wait", 1, n >= 16 && n <= 30);
        check("ratio", ratio, clk_ratio);
        check("reserved", r == 2'h3, ratio_reserved);
        check("boot mode", 2'h2 ^ r, boot_mode);
        check("vector", 24'h090000, fetch_addr);
        check("reset out", 1, reset_output_pin_n);
    endtask
    task t_strobes;
        @(posedge ref_clk) rd_n_core <= 1'b0;
        ale_core <= 1'b1;
        repeat (2) @(posedge ref_clk) #1;
        check("strobes", 3'h3, {rd_n_out, wr_n_out, ale_out});
        check("strobe oe", 0, {rd_n_oe_n, wr_n_oe_n, ale_oe_n});
        check("fixed", 3'h4, {in_pins_oe_n, in_pins_pu_en, out_pins_oe_n});
        fork board_src_i.power_up(2'h0, 2'h0); join_none
        repeat (6) @(posedge ref_clk) #1;
        check("oe in reset", 3'h7, {rd_n_oe_n, wr_n_oe_n, ale_oe_n});
        check("run in reset", 0, {core_run, reset_output_pin_n});
        check("test port", 1, test_port_reset);
        wait fork;
    endtask
    task t_tdo;
        @(posedge ref_clk) scan_shift <= 1'b1;
        scan_data <= 1'b1;
        repeat (3) @(posedge ref_clk) #1;
        check("tdo", 2'h1, {tdo_oe_n, tdo_out});
        @(posedge ref_clk) scan_shift <= 1'b0;
        repeat (3) @(posedge ref_clk) #1;
        check("tdo off", 1, tdo_oe_n);
    endtask
    task t_trst;
        @(posedge ref_clk) scan_shift <= 1'b1;
        board_src_i.set_trst(1'b0);
        repeat (6) @(posedge ref_clk) #1;
        check("trst held", 2'h3, {test_port_reset, tdo_oe_n});
        board_src_i.set_trst(1'b1);
        repeat (6) @(posedge ref_clk) #1;
        check("trst free", 2'h0, {test_port_reset, tdo_oe_n});
        @(posedge ref_clk) scan_shift <= 1'b0;
    endtask
    initial begin
        t_boot(2'h0, 6'h06);
        t_boot(2'h1, 6'h20);
        t_boot(2'h2, 6'h10);
        t_boot(2'h3, 6'h06);
        t_strobes();
        t_tdo();
        t_trst();
        conclude();
    end
endmodule // tb_reset_boot_sequencing
